// ---- rtl/udt_pkg.sv ----
// udt_pkg: constants and types for the up/down reload timer with clock out.
// assumes a 32-bit apb slave with byte addresses, one register per word.
package udt_pkg;

  // register indices; byte address is four times the index
  localparam logic [7:0]  IDX_CTRL    = 8'hC8;
  localparam logic [7:0]  IDX_MODE    = 8'hC9;
  localparam logic [7:0]  IDX_RLD_LO  = 8'hCA;
  localparam logic [7:0]  IDX_RLD_HI  = 8'hCB;
  localparam logic [7:0]  IDX_CNT_LO  = 8'hCC;
  localparam logic [7:0]  IDX_CNT_HI  = 8'hCD;
  localparam int          ADDR_W      = 12;

  // timer_control_reg bit positions
  localparam int BIT_OVF      = 7;  // overflow_flag
  localparam int BIT_EXT      = 6;  // external_flag
  localparam int BIT_RX_BAUD  = 5;  // rx_baud_select
  localparam int BIT_TX_BAUD  = 4;  // tx_baud_select
  localparam int BIT_EXT_EN   = 3;  // direction pin edge trigger enable
  localparam int BIT_RUN      = 2;  // run_control
  localparam int BIT_SRC      = 1;  // count_source_select
  localparam int BIT_CAP      = 0;  // capture_reload_select

  // timer_mode_reg bit positions
  localparam int BIT_CLK_OE   = 1;  // clock_out_enable
  localparam int BIT_DOWN_EN  = 0;  // down_count_enable

  // values after reset, and the top of the count
  localparam logic [7:0]  CTRL_RST    = 8'h00;
  localparam logic [1:0]  MODE_RST    = 2'h0;
  localparam logic [15:0] COUNT_RST   = 16'h0000;
  localparam logic [15:0] RELOAD_RST  = 16'h0000;
  localparam logic [15:0] COUNT_MAX   = 16'hFFFF;

  // oscillator divide ratios for the internal tick
  localparam logic [3:0]  DIV_TIMER   = 4'hC;  // twelve
  localparam logic [3:0]  DIV_CLKOUT  = 4'h2;  // two

  // operating modes, gray coded
  typedef enum logic [1:0] {
    UDT_MODE_RELOAD  = 2'b00,
    UDT_MODE_UPDOWN  = 2'b01,
    UDT_MODE_CAPTURE = 2'b11,
    UDT_MODE_BAUD    = 2'b10
  } udt_mode_e;

  // drive of the shared count/clock-out pin
  typedef struct packed {
    logic out;
    logic oe;
  } udt_pin_s;

  // whole state of the timer block
  typedef struct packed {
    logic [7:0]  ctrl;
    logic [1:0]  mode;
    logic [15:0] cnt;
    logic [15:0] rld;
    logic [3:0]  presc;
    logic        pin_q;
    logic        dir_q;
    logic        clk_out;
    logic [31:0] rdata;
    logic        rd_err;
  } udt_state_s;

endpackage

// ---- rtl/udt_timer.sv ----
// udt_timer: 16-bit up/down auto-reload timer/counter with clock output.
// assumes pclk is the oscillator, pins are synchronous to pclk, apb master.
//
// Added by the designer: the APB register port and the address map.
`timescale 1ns/1ns

// Contract
// R1: count is two cascaded 8-bit halves
// R2: source is clock/12 or count pin events
// R3: count advances only while run_control set
// R4: three modes chosen by baud and capture bits
// R5: down_count_enable clear gives plain up reload
// R6: up direction overflow sets flag, requests interrupt
// R7: up overflow loads reload value into count
// R8: down direction underflows when count equals reload
// R9: underflow sets flag and loads FFFFh
// R10: updown wrap toggles external_flag, no interrupt
// R11: clock-out mode makes 50% duty square wave
// R12: clock-out mode counts at clock/2 repeatedly
// R13: clock-out overflows reload, raise no interrupt
// R14: output rate is clock/(4*(65536-reload))
// R15: clock output shares the count input pin
// R16: software sets enable, clears source, then runs
// R17: baud generation and clock out may coexist
// R18: overflow_flag set only when both baud bits clear
// R19: rx_baud_select picks this timer for receive clock
// R20: clock-out pin toggles on every overflow
module udt_timer (
  input  wire logic                         pclk,
  input  wire logic                         presetn,
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [udt_pkg::ADDR_W-1:0]   paddr,
  input  wire logic [31:0]                  pwdata,
  output logic                              pready,
  output logic [31:0]                       prdata,
  output logic                              pslverr,
  input  wire logic                         count_input_pin,
  output udt_pkg::udt_pin_s                 count_pin_drv,
  input  wire logic                         direction_input,
  input  wire logic                         other_timer_ovf,
  output logic                              timer_irq,
  output logic                              rx_baud_tick,
  output logic                              tx_baud_tick
);

  udt_pkg::udt_state_s s_r;
  udt_pkg::udt_state_s s_nxt;

  // mode from the control and mode bits; baud bits take precedence
  // capture_reload_select is ignored while either baud bit is set
  function automatic udt_pkg::udt_mode_e mode_of(
    input logic [7:0] ctrl,
    input logic [1:0] mode
  );
    if (ctrl[udt_pkg::BIT_RX_BAUD] || ctrl[udt_pkg::BIT_TX_BAUD]) begin
      return udt_pkg::UDT_MODE_BAUD;
    end else if (ctrl[udt_pkg::BIT_CAP]) begin
      return udt_pkg::UDT_MODE_CAPTURE;
    end else if (mode[udt_pkg::BIT_DOWN_EN]) begin
      return udt_pkg::UDT_MODE_UPDOWN;
    end else begin
      return udt_pkg::UDT_MODE_RELOAD;
    end
  endfunction

  // word address match against a register index
  // the index sits two bits up: one register per 32-bit word
  function automatic logic hit(
    input logic [udt_pkg::ADDR_W-1:0] addr,
    input logic [7:0]                 idx
  );
    return addr == {2'h0, idx, 2'h0};
  endfunction

  // mode decode and internal prescaler
  udt_pkg::udt_mode_e mode;
  logic               clkout_mode;
  logic [3:0]         div;
  logic               tick_int;
  // pin edges, found against the level held from the last edge
  logic               pin_fall;
  logic               dir_fall;
  // count events of this cycle
  logic               tick;
  logic               up;
  logic               ovf_up;
  logic               unf;
  logic               wrap;
  logic               ext_ev;
  // register bus decode
  logic               wr;
  logic               setup;
  logic               mapped;

  // event decode from current state and pins
  always_comb begin
    mode        = mode_of(s_r.ctrl, s_r.mode);
    // clock out needs the internal source selected
    clkout_mode = s_r.mode[udt_pkg::BIT_CLK_OE]
                  && !s_r.ctrl[udt_pkg::BIT_SRC];            // R16
    div         = clkout_mode ? udt_pkg::DIV_CLKOUT
                              : udt_pkg::DIV_TIMER;          // R2 R12
    tick_int    = s_r.presc == div - 4'h1;
    // held levels reset low: no false fall straight after reset
    // limitation: the count pin must stay high and low a clock each
    pin_fall    = s_r.pin_q && !count_input_pin;
    dir_fall    = s_r.dir_q && !direction_input;
    tick        = s_r.ctrl[udt_pkg::BIT_RUN]
                  && (s_r.ctrl[udt_pkg::BIT_SRC] ? pin_fall
                                                 : tick_int); // R2 R3
    // only up/down mode may count down
    up          = !(mode == udt_pkg::UDT_MODE_UPDOWN
                    && !direction_input);                    // R5 R6 R8
    ovf_up      = tick && up && s_r.cnt == udt_pkg::COUNT_MAX;
    // underflow compares against the reload value, not zero
    unf         = tick && !up && s_r.cnt == s_r.rld;         // R8
    wrap        = ovf_up || unf;
    ext_ev      = s_r.ctrl[udt_pkg::BIT_EXT_EN] && dir_fall
                  && mode != udt_pkg::UDT_MODE_UPDOWN;
    // read data is captured in setup so the access never waits
    setup       = psel && !penable;
    wr          = psel && penable && pwrite;
    // unmapped words answer with pslverr and read as zero
    mapped      = hit(paddr, udt_pkg::IDX_CTRL)
                  || hit(paddr, udt_pkg::IDX_MODE)
                  || hit(paddr, udt_pkg::IDX_RLD_LO)
                  || hit(paddr, udt_pkg::IDX_RLD_HI)
                  || hit(paddr, udt_pkg::IDX_CNT_LO)
                  || hit(paddr, udt_pkg::IDX_CNT_HI);
  end

  // next state: counting first, software writes and flag sets after
  always_comb begin
    s_nxt       = s_r;
    s_nxt.pin_q = count_input_pin;
    s_nxt.dir_q = direction_input;

    // prescaler restarts while stopped so the first tick is a full period
    if (!s_r.ctrl[udt_pkg::BIT_RUN] || tick_int) begin
      s_nxt.presc = 4'h0;
    end else begin
      s_nxt.presc = s_r.presc + 4'h1;
    end

    // 16-bit count, low byte carries into high byte
    if (tick) begin
      case (mode)
        // wraps both ways; the reload value is the floor going down
        udt_pkg::UDT_MODE_UPDOWN: begin
          if (ovf_up) begin
            s_nxt.cnt = s_r.rld;                             // R7
          end else if (unf) begin
            s_nxt.cnt = udt_pkg::COUNT_MAX;                  // R9
          end else if (up) begin
            s_nxt.cnt = s_r.cnt + 16'h0001;                  // R1
          end else begin
            s_nxt.cnt = s_r.cnt - 16'h0001;
          end
        end
        // capture counts freely; the direction pin copies the count
        udt_pkg::UDT_MODE_CAPTURE: begin
          s_nxt.cnt = s_r.cnt + 16'h0001;                    // R4
        end
        // reload and baud share one reload value with clock out
        udt_pkg::UDT_MODE_RELOAD, udt_pkg::UDT_MODE_BAUD: begin
          if (ovf_up) begin
            s_nxt.cnt = s_r.rld;                             // R7 R13 R17
          end else begin
            s_nxt.cnt = s_r.cnt + 16'h0001;                  // R1 R12
          end
        end
        default: begin
          s_nxt.cnt = s_r.cnt;
        end
      endcase
    end

    // falling direction pin: reload or capture when enabled
    if (ext_ev && mode == udt_pkg::UDT_MODE_RELOAD) begin
      s_nxt.cnt = s_r.rld;
    end
    if (ext_ev && mode == udt_pkg::UDT_MODE_CAPTURE) begin
      s_nxt.rld = s_r.cnt;
    end

    // clearing the enable parks the level low, so a re-enable
    // always starts from the same phase
    // pin toggles per overflow: period spans two overflow intervals
    if (clkout_mode && ovf_up) begin
      s_nxt.clk_out = !s_r.clk_out;                          // R11 R14 R20
    end else if (!s_r.mode[udt_pkg::BIT_CLK_OE]) begin
      s_nxt.clk_out = 1'b0;
    end

    // software writes take effect at the access edge
    // registers are at most eight bits wide (mode is two); upper write data is ignored
    // halves are not latched together: stop the timer before
    // changing a 16-bit value that must switch in one step
    if (wr) begin
      if (hit(paddr, udt_pkg::IDX_CTRL)) begin
        s_nxt.ctrl = pwdata[7:0];
      end
      if (hit(paddr, udt_pkg::IDX_MODE)) begin
        s_nxt.mode = pwdata[1:0];
      end
      if (hit(paddr, udt_pkg::IDX_RLD_LO)) begin
        s_nxt.rld[7:0] = pwdata[7:0];
      end
      if (hit(paddr, udt_pkg::IDX_RLD_HI)) begin
        s_nxt.rld[15:8] = pwdata[7:0];
      end
      // a count write overrides the hardware step in the same cycle
      if (hit(paddr, udt_pkg::IDX_CNT_LO)) begin
        s_nxt.cnt[7:0] = pwdata[7:0];
      end
      if (hit(paddr, udt_pkg::IDX_CNT_HI)) begin
        s_nxt.cnt[15:8] = pwdata[7:0];
      end
    end

    // hardware sets win over a software clear in the same cycle
    // baud and clock-out overflows are rate events, not interrupts
    if (wrap && !s_r.ctrl[udt_pkg::BIT_RX_BAUD]
        && !s_r.ctrl[udt_pkg::BIT_TX_BAUD] && !clkout_mode) begin
      s_nxt.ctrl[udt_pkg::BIT_OVF] = 1'b1;                   // R6 R9 R18
    end
    // external_flag doubles as a seventeenth count bit here
    if (wrap && mode == udt_pkg::UDT_MODE_UPDOWN) begin
      s_nxt.ctrl[udt_pkg::BIT_EXT] = !s_r.ctrl[udt_pkg::BIT_EXT]; // R10
    end else if (ext_ev) begin
      s_nxt.ctrl[udt_pkg::BIT_EXT] = 1'b1;
    end

    // read data latched in the setup cycle, presented in access
    // only bits that exist are returned; the rest read as zero
    if (setup) begin
      s_nxt.rd_err = !mapped;
      s_nxt.rdata  = 32'h0000_0000;
      if (hit(paddr, udt_pkg::IDX_CTRL)) begin
        s_nxt.rdata[7:0] = s_r.ctrl;
      end
      if (hit(paddr, udt_pkg::IDX_MODE)) begin
        s_nxt.rdata[1:0] = s_r.mode;
      end
      if (hit(paddr, udt_pkg::IDX_RLD_LO)) begin
        s_nxt.rdata[7:0] = s_r.rld[7:0];
      end
      if (hit(paddr, udt_pkg::IDX_RLD_HI)) begin
        s_nxt.rdata[7:0] = s_r.rld[15:8];
      end
      if (hit(paddr, udt_pkg::IDX_CNT_LO)) begin
        s_nxt.rdata[7:0] = s_r.cnt[7:0];
      end
      if (hit(paddr, udt_pkg::IDX_CNT_HI)) begin
        s_nxt.rdata[7:0] = s_r.cnt[15:8];
      end
    end
  end

  // single state register
  // the reset branch loads constants only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r.ctrl    <= udt_pkg::CTRL_RST;
      s_r.mode    <= udt_pkg::MODE_RST;
      s_r.cnt     <= udt_pkg::COUNT_RST;
      s_r.rld     <= udt_pkg::RELOAD_RST;
      s_r.presc   <= 4'h0;
      s_r.pin_q   <= 1'b0;
      s_r.dir_q   <= 1'b0;
      s_r.clk_out <= 1'b0;
      s_r.rdata   <= 32'h0000_0000;
      s_r.rd_err  <= 1'b0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // apb answer: one access cycle, no wait states
  // trade-off: a read shows the register as it stood in setup
  assign pready  = psel && penable;
  assign prdata  = s_r.rdata;
  assign pslverr = psel && penable && s_r.rd_err;

  // pin is driven only while clock output is enabled
  // when disabled the pin is left to the outside event source
  assign count_pin_drv.out = s_r.clk_out;                    // R15
  assign count_pin_drv.oe  = s_r.mode[udt_pkg::BIT_CLK_OE];  // R15

  // external_flag requests no interrupt in up/down mode
  assign timer_irq = s_r.ctrl[udt_pkg::BIT_OVF]
                     || (s_r.ctrl[udt_pkg::BIT_EXT]
                         && !s_r.mode[udt_pkg::BIT_DOWN_EN]); // R6 R10 R13

  // serial clock selection; combinational pulse of the overflow
  // a consumer must sample these ticks on pclk
  assign rx_baud_tick = s_r.ctrl[udt_pkg::BIT_RX_BAUD] ? ovf_up
                                                       : other_timer_ovf; // R19
  assign tx_baud_tick = s_r.ctrl[udt_pkg::BIT_TX_BAUD] ? ovf_up
                                                       : other_timer_ovf; // R17

endmodule

// ---- dv/udt_timer_checker.sv ----
// udt_timer_checker: bus and pin assertions for the reload timer.
// assumes it is bound onto udt_timer and sees only its ports.
`timescale 1ns/1ns
module udt_timer_checker (
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic              pready,
  input wire logic [31:0]       prdata,
  input wire logic              pslverr,
  input wire udt_pkg::udt_pin_s count_pin_drv,
  input wire logic              other_timer_ovf,
  input wire logic              rx_baud_tick
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // a toggle of the driven clock-out level
  sequence s_toggle;
    count_pin_drv.oe && $past(count_pin_drv.oe) && $changed(count_pin_drv.out);
  endsequence
  a_ready_access: assert property (psel && penable |-> pready)
    else $error("pready low in access");
  a_ready_idle: assert property (!(psel && penable) |-> !pready)
    else $error("pready outside access");
  a_err_access: assert property (pslverr |-> psel && penable)
    else $error("pslverr outside access");
  a_err_rdata: assert property (pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read returned data");
  a_rdata_setup: assert property (
    $changed(prdata) |-> $past(psel && !penable))
    else $error("prdata moved outside setup");
  a_pin_spacing: assert property (
    s_toggle |=> $stable(count_pin_drv.out) || !count_pin_drv.oe)
    else $error("clock out toggled twice in a row");
  a_pin_idle: assert property (
    !count_pin_drv.oe && !$past(count_pin_drv.oe) |-> !count_pin_drv.out)
    else $error("clock out high while not driven");
  a_tick_pulse: assert property (
    rx_baud_tick && !other_timer_ovf |=> !rx_baud_tick || other_timer_ovf)
    else $error("receive tick longer than a cycle");
endmodule

bind udt_timer udt_timer_checker u_chk (.pclk, .presetn, .psel, .penable,
  .pwrite, .pready, .prdata, .pslverr, .count_pin_drv, .other_timer_ovf,
  .rx_baud_tick);

// ---- dv/udt_pin_model.sv ----
// udt_pin_model: shared count/clock-out pin and the direction pin.
// assumes the bench calls pulse() for events and sets dir_up.
`timescale 1ns/1ns
module udt_pin_model (
  input wire logic              pclk,
  input wire udt_pkg::udt_pin_s drv,
  output logic                  pin_w,
  output logic                  direction_input
);
  logic ext_lvl = 1'b1;  // pull-up keeps the pin high when idle
  logic dir_up = 1'b1;
  // timer owns the pin in clock-out, else the external source
  assign pin_w = drv.oe ? drv.out : ext_lvl;
  assign direction_input = dir_up;
  // events two clocks low, so the edge detector never misses one
  task automatic pulse(input int n);
    repeat (n) begin
      @(posedge pclk);
      ext_lvl <= 1'b0;
      repeat (2) @(posedge pclk);
      ext_lvl <= 1'b1;
      @(posedge pclk);
    end
  endtask
endmodule

// ---- dv/udt_timer_tb.sv ----
// udt_timer_tb: register-level tests of the reload timer over apb.
// assumes the pin model on the far side and the bound checker.
`timescale 1ns/1ns
module udt_timer_tb;
  logic              pclk = 1'b0;
  logic              presetn = 1'b0;
  logic              psel = 1'b0;
  logic              penable = 1'b0;
  logic              pwrite = 1'b0;
  logic [11:0]       paddr = 12'h000;
  logic [31:0]       pwdata = 32'h0;
  logic              other_timer_ovf = 1'b0;
  logic              pready, pslverr, timer_irq, rx_baud_tick, tx_baud_tick;
  logic [31:0]       prdata, q;
  logic              pin_w, direction_input, err;
  udt_pkg::udt_pin_s count_pin_drv;
  int                miscompares = 0;
  int                checks = 0;
  int                n, m;
  always #5 pclk = ~pclk;
  udt_timer u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pready, .prdata, .pslverr, .count_input_pin(pin_w),
    .count_pin_drv, .direction_input, .other_timer_ovf, .timer_irq,
    .rx_baud_tick, .tx_baud_tick);
  udt_pin_model u_pins (.pclk, .drv(count_pin_drv), .pin_w, .direction_input);
  task automatic chk(input string       nm,
                     input logic [31:0] e,
                     input logic [31:0] g);
    checks++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  // one transfer, held until pready is seen high at an edge
  task automatic apb(input logic        w,
                     input logic [7:0]  idx,
                     input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {2'h0, idx, 2'h0};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 16);
    // a bus that never answers is a failure, not a silent skip
    if (pready !== 1'b1) begin
      miscompares++;
      $display("BAD pready exp 1 got %b", pready);
    end
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input string       nm,
                    input logic [7:0]  idx,
                    input logic [31:0] e);
    apb(1'b0, idx, 32'h0);
    chk(nm, e, q);
  endtask
  task automatic load(input logic [15:0] r, input logic [15:0] c);
    apb(1'b1, udt_pkg::IDX_RLD_LO, {24'h0, r[7:0]});
    apb(1'b1, udt_pkg::IDX_RLD_HI, {24'h0, r[15:8]});
    apb(1'b1, udt_pkg::IDX_CNT_LO, {24'h0, c[7:0]});
    apb(1'b1, udt_pkg::IDX_CNT_HI, {24'h0, c[15:8]});
  endtask
  // bounded wait for the interrupt, sampled after the edge settles
  task automatic wait_irq(output int k);
    k = 0;
    do begin
      @(posedge pclk);
      #1 k++;
    end while (timer_irq !== 1'b1 && k < 100);
  endtask
  task automatic conclude();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    #100000;
    miscompares++;
    conclude();
  end
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      rd("reset", udt_pkg::IDX_CTRL + 8'(i), 32'h0);
    end
    apb(1'b0, 8'h10, 32'h0);
    chk("unmapped", 32'h1, {31'h0, err});
    // up count from FFFE wraps after two ticks of twelve clocks
    load(16'hFFFE, 16'hFFFE);
    apb(1'b1, udt_pkg::IDX_CTRL, 32'h04);
    wait_irq(n);
    chk("up wrap", 32'h1, {31'h0, n >= 23 && n <= 25});
    rd("up ctrl", udt_pkg::IDX_CTRL, 32'h84);
    apb(1'b1, udt_pkg::IDX_CTRL, 32'h00);
    rd("up lo", udt_pkg::IDX_CNT_LO, 32'hFE);
    rd("up hi", udt_pkg::IDX_CNT_HI, 32'hFF);
    repeat (40) @(posedge pclk);
    rd("held", udt_pkg::IDX_CNT_LO, 32'hFE);
    // down count reaches the reload value, then FFFF is loaded
    u_pins.dir_up <= 1'b0;
    apb(1'b1, udt_pkg::IDX_MODE, 32'h01);
    load(16'hFFFE, 16'hFFFF);
    apb(1'b1, udt_pkg::IDX_CTRL, 32'h04);
    wait_irq(n);
    chk("down wrap", 32'h1, {31'h0, n >= 23 && n <= 25});
    rd("down ctrl", udt_pkg::IDX_CTRL, 32'hC4);
    apb(1'b1, udt_pkg::IDX_CTRL, 32'h40);
    rd("down lo", udt_pkg::IDX_CNT_LO, 32'hFF);
    chk("ext no irq", 32'h0, {31'h0, timer_irq});
    apb(1'b1, udt_pkg::IDX_CTRL, 32'h00);
    apb(1'b1, udt_pkg::IDX_MODE, 32'h00);
    u_pins.dir_up <= 1'b1;
    // pin events carry from the low half into the high half
    load(16'h0000, 16'h00FE);
    apb(1'b1, udt_pkg::IDX_CTRL, 32'h06);
    u_pins.pulse(3);
    rd("event lo", udt_pkg::IDX_CNT_LO, 32'h01);
    rd("event hi", udt_pkg::IDX_CNT_HI, 32'h01);
    // baud mode: this timer feeds both ticks, no flag
    load(16'hFFFE, 16'hFFFE);
    apb(1'b1, udt_pkg::IDX_CTRL, 32'h34);
    n = 0;
    m = 0;
    repeat (60) begin
      @(posedge pclk);
      #1 n += int'(rx_baud_tick);
      m += int'(tx_baud_tick);
    end
    chk("baud ticks", 32'h1, {31'h0, n > 0 && n == m});
    rd("baud ctrl", udt_pkg::IDX_CTRL, 32'h34);
    apb(1'b1, udt_pkg::IDX_CTRL, 32'h00);
    @(posedge pclk);
    other_timer_ovf <= 1'b1;
    #1 chk("other ovf", 32'h1, {31'h0, rx_baud_tick});
    chk("other tx", 32'h1, {31'h0, tx_baud_tick});
    @(posedge pclk);
    other_timer_ovf <= 1'b0;
    // direction pin falling edge: capture, then reload, when enabled
    load(16'h0000, 16'h0010);
    apb(1'b1, udt_pkg::IDX_CTRL, 32'h09);
    u_pins.dir_up <= 1'b0;
    rd("cap rld", udt_pkg::IDX_RLD_LO, 32'h10);
    rd("cap ctrl", udt_pkg::IDX_CTRL, 32'h49);
    u_pins.dir_up <= 1'b1;
    apb(1'b1, udt_pkg::IDX_CNT_LO, 32'h55);
    apb(1'b1, udt_pkg::IDX_CTRL, 32'h08);
    u_pins.dir_up <= 1'b0;
    rd("trig lo", udt_pkg::IDX_CNT_LO, 32'h10);
    rd("trig ctrl", udt_pkg::IDX_CTRL, 32'h48);
    chk("trig irq", 32'h1, {31'h0, timer_irq});
    apb(1'b1, udt_pkg::IDX_CTRL, 32'h00);
    u_pins.dir_up <= 1'b1;
    // clock out, reload FFF0: 32 clocks high, 32 low
    apb(1'b1, udt_pkg::IDX_MODE, 32'h02);
    load(16'hFFF0, 16'hFFF0);
    apb(1'b1, udt_pkg::IDX_CTRL, 32'h04);
    for (int ph = 0; ph < 3; ph++) begin
      n = 0;
      do begin
        @(posedge pclk);
        #1 n++;
      end while (pin_w === (ph != 0 && ph != 2 ? 1'b1 : 1'b0) && n < 200);
      if (ph == 1) chk("high", 32'h20, 32'(n));
      if (ph == 2) chk("low", 32'h20, 32'(n));
    end
    chk("pin oe", 32'h1, {31'h0, count_pin_drv.oe});
    chk("pin", 32'h1, {31'h0, pin_w});
    chk("no irq", 32'h0, {31'h0, timer_irq});
    rd("co ctrl", udt_pkg::IDX_CTRL, 32'h04);
    apb(1'b1, udt_pkg::IDX_MODE, 32'h00);
    conclude();
  end
endmodule
